/* File: include/asp_pkg.sv */
`default_nettype none
package asp_pkg;
  // register word indices; the byte address is four times the index
  localparam logic [15:0] IDX_CTRL_A = 16'h1F91; // status on read
  localparam logic [15:0] IDX_CTRL_B = 16'h1F92;
  localparam logic [15:0] IDX_DATA = 16'h1F93; // rx on read, tx on write
  localparam logic [15:0] IDX_ROUTE = 16'h1F94;
  // control a field positions
  localparam int A_TXE = 7;
  localparam int A_RXE = 6;
  localparam int A_TSTOP = 5;
  localparam int A_EVEN = 4;
  localparam int A_PAR = 3;
  localparam int A_BAUD = 0;
  // control b field positions
  localparam int B_RSTOP = 0;
  localparam int B_NF = 1;
  // route field positions
  localparam int R_RX = 0;
  localparam int R_TX = 1;
  // status field positions
  localparam int S_PARITY_ERR_FLAG = 7;
  localparam int S_FRAME_ERR_FLAG = 6;
  localparam int S_OVERRUN_FLAG = 5;
  localparam int S_RFULL = 4;
  localparam int S_TDONE = 3;
  localparam int S_TEMPTY = 2;
  // reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [2:0] CTRL_B_RST = 3'h0;
  localparam logic [1:0] ROUTE_RST = 2'h0;
  localparam logic [7:0] HOLD_RST = 8'h00;
  // transfer clock divisors in fc cycles, indexed by baud select
  localparam logic [8:0] DIV_0 = 9'h00D;
  localparam logic [8:0] DIV_1 = 9'h01A;
  localparam logic [8:0] DIV_2 = 9'h034;
  localparam logic [8:0] DIV_3 = 9'h068;
  localparam logic [8:0] DIV_4 = 9'h0D0;
  localparam logic [8:0] DIV_5 = 9'h1A0;
  localparam logic [8:0] DIV_7 = 9'h060;
  localparam logic [2:0] BAUD_TIMER = 3'h6;
  // noise filter: least stable time in fc cycles before a level is taken
  localparam logic [6:0] NF_REJ1 = 7'h1F;
  localparam logic [6:0] NF_REJ2 = 7'h3F;
  localparam logic [6:0] NF_REJ3 = 7'h7F;
  // sub-bit slots
  localparam logic [3:0] SLOT_A = 4'h7;
  localparam logic [3:0] SLOT_B = 4'h8;
  localparam logic [3:0] SLOT_C = 4'h9;
  localparam logic [3:0] SLOT_LAST = 4'hF;
  localparam logic [2:0] LAST_DATA = 3'h7;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asp_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_state_t;
endpackage : asp_pkg
`default_nettype wire

/* File: verification/asp_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_peer (
  // clock
  input wire logic aclk,
  // serial lines seen from the peripheral
  input wire logic tx_line,
  output logic rx_line
);
  // 16 ticks of fc/13 per bit
  localparam int BIT = 208;
  logic evn = 1'b1;
  // line has a pull-up, so it idles high between frames
  initial rx_line = 1'b1;
  task automatic send(input logic [7:0] d, input logic badp, input logic bads);
    logic [10:0] f;
    f = {~bads, ^d ^ ~evn ^ badp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (BIT) @(posedge aclk);
    end
    rx_line <= 1'b1;
    // one idle cycle, so back-to-back frames never drive the line twice in a step
    @(posedge aclk);
  endtask : send
  // sample mid-bit; returns in the middle of the first stop bit
  task automatic get(output logic [7:0] d, output logic p, output logic s);
    int n;
    n = 0;
    while (tx_line !== 1'b0 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT) @(posedge aclk);
      if (i < 8) d[i] = tx_line;
      else if (i == 8) p = tx_line;
      else s = tx_line;
    end
  endtask : get
endmodule : asp_peer
`default_nettype wire

/* File: verification/async_serial_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_bench;
  localparam logic [15:0] AD_A = asp_pkg::IDX_CTRL_A << 2;
  localparam logic [15:0] AD_B = asp_pkg::IDX_CTRL_B << 2;
  localparam logic [15:0] AD_D = asp_pkg::IDX_DATA << 2;
  localparam logic [15:0] AD_R = asp_pkg::IDX_ROUTE << 2;
  localparam logic [15:0] AD_X = 16'h7E60;
  localparam logic [1:0] OK = asp_pkg::RESP_OKAY;
  localparam logic [1:0] ER = asp_pkg::RESP_SLVERR;
  localparam int BIT = 208;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tmr, line, quiet;
  logic awready, wready, bvalid, arready, rvalid, tx_p, tx_a, tx_irq, rx_irq, rx_p, rx_a;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rt;
  logic [7:0] d;
  logic p, s;
  logic [7:0] rxd [3] = '{8'h3C, 8'h5A, 8'h11};
  logic [7:0] rxs [3] = '{8'h1C, 8'h9C, 8'h5C};
  logic [2:0] bp = 3'h2;
  logic [2:0] bs = 3'h4;
  int num_errors = 0, checks_done = 0, n_tx = 0, stray = 0, n_rx = 0, tc = 0;
  // unselected receive pin rests at its pull-up level
  assign rx_p = rt[0] ? 1'b1 : line;
  assign rx_a = rt[0] ? line : 1'b1;
  asp_uart DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_pin_primary(rx_p), .rx_pin_alternate(rx_a),
    .timer4_event(tmr), .tx_pin_primary(tx_p), .tx_pin_alternate(tx_a),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  asp_peer peer (.aclk(aclk), .tx_line(rt[1] ? tx_a : tx_p), .rx_line(line));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // count character events and any low level on a pin that must stay idle
  // port latch and direction sit outside; pins idle high
  // no synchronous unit here, primary pair free
  always @(posedge aclk) begin
    if (tx_irq === 1'b1) n_tx++;
    if (rx_irq === 1'b1) n_rx++;
    // timer event every 13 cycles, so timer mode keeps the same bit time
    tc <= (tc == 12) ? 0 : tc + 1;
    tmr <= (tc == 12);
    if (aresetn && (((quiet || rt[1]) && tx_p !== 1'b1) || ((quiet || !rt[1]) && tx_a !== 1'b1)))
      stray++;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_resp
  // address and data offered together, each held until taken
  task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk_resp("bresp", er, bresp);
    // bready stays high, so a following call never drives it twice in one step
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    chk_resp("rresp", er, rresp);
    chk_byte("rdata", e, rdata[7:0]);
    // rready stays high for the same reason as bready
    @(posedge aclk);
  endtask : rd
  // watchdog: all frames together need roughly 20000 cycles
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    $display("watchdog expired");
    give_verdict();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    rt = 2'h0;
    quiet = 1'b1;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(AD_A, 8'h0C, OK);
    rd(AD_D, 8'h00, OK);
    rd(AD_X, 8'h00, ER);
    wr(AD_X, 8'h00, ER);
    wr(AD_B, 8'h00, OK);
    wr(AD_A, 8'hD8, OK);
    wr(AD_D, 8'h55, OK);
    repeat (3 * BIT) @(posedge aclk);
    chk_byte("tx starts", 8'h00, n_tx[7:0]);
    rd(AD_A, 8'h0C, OK);
    $display("test reset and unarmed write done");
    quiet <= 1'b0;
    fork
      peer.get(d, p, s);
      wr(AD_D, 8'hA7, OK);
    join
    chk_byte("tx data", 8'hA7, d);
    chk_byte("tx parity", 8'h01, {7'h0, p});
    chk_byte("tx stop", 8'h01, {7'h0, s});
    repeat (BIT) @(posedge aclk);
    chk_byte("tx events", 8'h01, n_tx[7:0]);
    rd(AD_A, 8'h0C, OK);
    $display("test transmit done");
    for (int i = 0; i < 3; i++) begin
      peer.send(rxd[i], bp[i], bs[i]);
      repeat (4) @(posedge aclk);
      rd(AD_A, rxs[i], OK);
      rd(AD_D, rxd[i], OK);
      rd(AD_A, 8'h0C, OK);
    end
    $display("test receive and errors done");
    // a cut stop bit leaves a false start behind; let it die out first
    repeat (BIT) @(posedge aclk);
    peer.send(8'h21, 1'b0, 1'b0);
    peer.send(8'h42, 1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    rd(AD_A, 8'h3C, OK);
    rd(AD_D, 8'h21, OK);
    rd(AD_A, 8'h0C, OK);
    chk_byte("rx events", 8'h04, n_rx[7:0]);
    $display("test overrun done");
    // both directions off before baud change
    wr(AD_A, 8'h08, OK);
    wr(AD_R, 8'h03, OK);
    wr(AD_B, 8'h02, OK);
    rt <= 2'h3;
    peer.evn = 1'b0;
    rd(AD_R, 8'h03, OK);
    wr(AD_A, 8'hCE, OK);
    peer.send(8'h69, 1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    rd(AD_A, 8'h1C, OK);
    rd(AD_D, 8'h69, OK);
    rd(AD_A, 8'h0C, OK);
    fork
      peer.get(d, p, s);
      begin
        wr(AD_D, 8'h96, OK);
        repeat (BIT) @(posedge aclk);
        wr(AD_A, 8'h0E, OK);
      end
    join
    chk_byte("late disable data", 8'h96, d);
    chk_byte("odd parity", 8'h01, {7'h0, p});
    wr(AD_A, 8'hCE, OK);
    repeat (2 * BIT) @(posedge aclk);
    chk_byte("tx events", 8'h02, n_tx[7:0]);
    chk_byte("idle pin lows", 8'h00, stray[7:0]);
    $display("test routing and late disable done");
    give_verdict();
  end
endmodule : async_serial_port_bench
`default_nettype wire

/* File: verilog/asp_uart.sv */
// Functional notes
// - disable takes effect after current character
// - old buffered data never sent on enable
// - one clock and parity for both directions
// - baud select picks divisor or timer event
// - timer mode: event is transfer clock
// - noise filter rejects pulses under 31, 63, 127 cycles
// - longer pulses always pass the filter
// - receive stop length one or two
// - status reports six read-only flags
// - tx event sets transmit empty flag
// - route bits pick primary or alternate pins
// - low start, data, parity, high stops
// - parity enable and odd/even select
// - transmit stop length one or two
// - idle receiver hunts low level each tick
// - sample each bit at slots 7, 8, 9
// - majority of three samples decides bit
// - status read must precede transmit write
// - armed data read clears receive flags
// - overrun discards new character, keeps old
// - tx pin high once idle, whether disabled or unloaded
`timescale 1ns/1ps
`default_nettype none
module asp_uart (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins and timer event
  input wire logic rx_pin_primary,
  input wire logic rx_pin_alternate,
  input wire logic timer4_event,
  output logic tx_pin_primary,
  output logic tx_pin_alternate,
  // character events
  output logic tx_irq,
  output logic rx_irq
);
  logic [7:0] ctrl_a_q;
  logic [2:0] ctrl_b_q;
  logic [1:0] route_q;
  logic armed_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_go, rd_go, wr_ok, rd_ok;
  logic [15:0] wr_idx, rd_idx;
  logic tx_load, clr_rx;
  logic tx_empty_q, tx_done_q, tx_pend_q, tx_irq_q, rx_irq_q;
  logic parity_err_flag_q, frame_err_flag_q, overrun_flag_q, rfull_q;
  logic [7:0] tx_hold_q, rx_hold_q;
  logic [7:0] status;

  // control fields
  logic tx_en, rx_en, even, par_en;
  logic [2:0] baud_sel;
  logic [1:0] nf_sel;
  assign tx_en = ctrl_a_q[asp_pkg::A_TXE];
  assign rx_en = ctrl_a_q[asp_pkg::A_RXE];
  assign even = ctrl_a_q[asp_pkg::A_EVEN];
  assign par_en = ctrl_a_q[asp_pkg::A_PAR];
  assign baud_sel = ctrl_a_q[asp_pkg::A_BAUD +: 3];
  assign nf_sel = ctrl_b_q[asp_pkg::B_NF +: 2];

  // bus handshakes: one write and one read outstanding at most
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = ~rvalid_q;
  assign wr_go = s_axi_awready;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign wr_idx = {2'h0, s_axi_awaddr[15:2]};
  assign rd_idx = {2'h0, s_axi_araddr[15:2]};
  assign wr_ok = wr_idx inside {asp_pkg::IDX_CTRL_A, asp_pkg::IDX_CTRL_B,
                                asp_pkg::IDX_DATA, asp_pkg::IDX_ROUTE};
  assign rd_ok = rd_idx inside {asp_pkg::IDX_CTRL_A, asp_pkg::IDX_CTRL_B,
                                asp_pkg::IDX_DATA, asp_pkg::IDX_ROUTE};
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // transmit write only when armed; buffer must be free too
  assign tx_load = wr_go & (wr_idx == asp_pkg::IDX_DATA) & s_axi_wstrb[0]
                   & armed_q & tx_empty_q & tx_en;
  // armed read of receive data clears receive flags
  assign clr_rx = rd_go & (rd_idx == asp_pkg::IDX_DATA) & armed_q;

  // write response, unmapped address answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= asp_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? asp_pkg::RESP_OKAY : asp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // control registers; write-only ones do not read back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q <= asp_pkg::CTRL_A_RST;
      ctrl_b_q <= asp_pkg::CTRL_B_RST;
      route_q <= asp_pkg::ROUTE_RST;
    end else if (wr_go && s_axi_wstrb[0]) begin
      if (wr_idx == asp_pkg::IDX_CTRL_A) ctrl_a_q <= s_axi_wdata[7:0];
      if (wr_idx == asp_pkg::IDX_CTRL_B) ctrl_b_q <= s_axi_wdata[2:0];
      if (wr_idx == asp_pkg::IDX_ROUTE) route_q <= s_axi_wdata[1:0];
    end
  end

  // status byte, low two bits read zero
  assign status = {parity_err_flag_q, frame_err_flag_q, overrun_flag_q, rfull_q, tx_done_q, tx_empty_q, 2'h0};

  // read data; shared addresses split by direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= asp_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? asp_pkg::RESP_OKAY : asp_pkg::RESP_SLVERR;
      case (rd_idx)
        asp_pkg::IDX_CTRL_A: rdata_q <= {24'h0, status};
        asp_pkg::IDX_DATA: rdata_q <= {24'h0, rx_hold_q};
        asp_pkg::IDX_ROUTE: rdata_q <= {30'h0, route_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // status read arms the next data access, which disarms
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
    end else if (rd_go && rd_idx == asp_pkg::IDX_CTRL_A) begin
      armed_q <= 1'b1;
    end else if ((rd_go && rd_idx == asp_pkg::IDX_DATA) ||
                 (wr_go && wr_idx == asp_pkg::IDX_DATA)) begin
      armed_q <= 1'b0;
    end
  end

  // transfer clock: divided fc or the timer event
  logic [8:0] div, div_cnt_q;
  logic tick;
  always_comb begin
    case (baud_sel)
      3'h0: div = asp_pkg::DIV_0;
      3'h1: div = asp_pkg::DIV_1;
      3'h2: div = asp_pkg::DIV_2;
      3'h3: div = asp_pkg::DIV_3;
      3'h4: div = asp_pkg::DIV_4;
      3'h5: div = asp_pkg::DIV_5;
      default: div = asp_pkg::DIV_7;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || div_cnt_q >= div - 9'h001) div_cnt_q <= 9'h000;
    else div_cnt_q <= div_cnt_q + 9'h001;
  end
  // timer mode uses the timer event as the transfer clock
  // one tick feeds both transmitter and receiver
  assign tick = (baud_sel == asp_pkg::BAUD_TIMER) ? timer4_event
              : (div_cnt_q == div - 9'h001);

  logic rx_raw, filt_q;
  logic [6:0] flt_cnt_q, thr;
  assign rx_raw = route_q[asp_pkg::R_RX] ? rx_pin_alternate : rx_pin_primary;
  always_comb begin
    case (nf_sel)
      2'h1: thr = asp_pkg::NF_REJ1;
      2'h2: thr = asp_pkg::NF_REJ2;
      default: thr = asp_pkg::NF_REJ3;
    endcase
  end
  // level taken only after thr stable cycles, or at once when nf_sel is 0
  // anything longer than thr always passes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_q <= 1'b1;
      flt_cnt_q <= 7'h00;
    end else if (nf_sel == 2'h0 || rx_raw == filt_q) begin
      filt_q <= rx_raw;
      flt_cnt_q <= 7'h00;
    end else if (flt_cnt_q == thr - 7'h01) begin
      filt_q <= rx_raw;
      flt_cnt_q <= 7'h00;
    end else begin
      flt_cnt_q <= flt_cnt_q + 7'h01;
    end
  end

  // transmitter
  asp_pkg::asp_tx_state_t tx_st_q;
  logic [3:0] tx_sub_q;
  logic [2:0] tx_bit_q;
  logic tx_stop_q, tx_par_q, tx_go, tx_end, tx_drop, tx_line;
  logic [7:0] tx_sh_q;
  // a new frame only starts from idle, so disable waits
  // start needs a fresh write, never just the enable
  assign tx_go = (tx_st_q == asp_pkg::TX_IDLE) & tx_en & tx_pend_q;
  assign tx_drop = (tx_st_q == asp_pkg::TX_IDLE) & ~tx_en & tx_pend_q;
  assign tx_end = (tx_st_q == asp_pkg::TX_STOP) & tick & (tx_sub_q == asp_pkg::SLOT_LAST)
                  & (tx_stop_q == ctrl_a_q[asp_pkg::A_TSTOP]);

  // transmit buffer and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold_q <= asp_pkg::HOLD_RST;
      tx_pend_q <= 1'b0;
      tx_empty_q <= 1'b1;
      tx_done_q <= 1'b1;
      tx_irq_q <= 1'b0;
    end else begin
      tx_irq_q <= tx_go;
      if (tx_load) tx_hold_q <= s_axi_wdata[7:0];
      tx_pend_q <= tx_load | (tx_pend_q & ~tx_go & ~tx_drop);
      // tx event sets the empty flag
      if (tx_go || tx_drop) tx_empty_q <= 1'b1;
      else if (tx_load) tx_empty_q <= 1'b0;
      if (tx_go) tx_done_q <= 1'b0;
      else if (tx_end && !tx_pend_q) tx_done_q <= 1'b1;
    end
  end

  // start, data, parity, stop in order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q <= asp_pkg::TX_IDLE;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_stop_q <= 1'b0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
    end else if (tx_go) begin
      tx_st_q <= asp_pkg::TX_START;
      tx_sub_q <= 4'h0;
      tx_sh_q <= tx_hold_q;
      // odd parity when even is clear
      tx_par_q <= (^tx_hold_q) ^ ~even;
    end else if (tick && tx_st_q != asp_pkg::TX_IDLE) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      if (tx_sub_q == asp_pkg::SLOT_LAST) begin
        case (tx_st_q)
          asp_pkg::TX_START: begin
            tx_st_q <= asp_pkg::TX_DATA;
            tx_bit_q <= 3'h0;
          end
          asp_pkg::TX_DATA: begin
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q + 3'h1;
            tx_stop_q <= 1'b0;
            if (tx_bit_q == asp_pkg::LAST_DATA)
              tx_st_q <= par_en ? asp_pkg::TX_PAR : asp_pkg::TX_STOP;
          end
          asp_pkg::TX_PAR: tx_st_q <= asp_pkg::TX_STOP;
          asp_pkg::TX_STOP: begin
            tx_stop_q <= 1'b1;
            if (tx_end) tx_st_q <= asp_pkg::TX_IDLE;
          end
          default: tx_st_q <= asp_pkg::TX_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    case (tx_st_q)
      asp_pkg::TX_START: tx_line = 1'b0;
      asp_pkg::TX_DATA: tx_line = tx_sh_q[0];
      asp_pkg::TX_PAR: tx_line = tx_par_q;
      default: tx_line = 1'b1;
    endcase
  end

  // transmit routing; idle and unselected pins stay high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pin_primary <= 1'b1;
      tx_pin_alternate <= 1'b1;
    end else begin
      tx_pin_primary <= route_q[asp_pkg::R_TX] | tx_line;
      tx_pin_alternate <= ~route_q[asp_pkg::R_TX] | tx_line;
    end
  end
  assign tx_irq = tx_irq_q;

  // receiver
  asp_pkg::asp_rx_state_t rx_st_q;
  logic [3:0] rx_sub_q;
  logic [2:0] rx_bit_q;
  logic [1:0] samp_q;
  logic [7:0] rx_sh_q;
  logic rx_stop_q, rx_pbad_q, rx_fbad_q, vote, vote_now, rx_done;
  assign vote = (samp_q[0] & samp_q[1]) | (samp_q[0] & filt_q) | (samp_q[1] & filt_q);
  assign vote_now = tick & (rx_sub_q == asp_pkg::SLOT_C) & (rx_st_q != asp_pkg::RX_IDLE);
  // one or two stop bits expected
  assign rx_done = vote_now & (rx_st_q == asp_pkg::RX_STOP)
                   & (rx_stop_q == ctrl_b_q[asp_pkg::B_RSTOP]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q <= asp_pkg::RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 3'h0;
      samp_q <= 2'h3;
      rx_sh_q <= 8'h00;
      rx_stop_q <= 1'b0;
      rx_pbad_q <= 1'b0;
      rx_fbad_q <= 1'b0;
    end else if (tick) begin
      rx_sub_q <= rx_sub_q + 4'h1;
      if (rx_sub_q == asp_pkg::SLOT_A || rx_sub_q == asp_pkg::SLOT_B)
        samp_q <= {samp_q[0], filt_q};
      case (rx_st_q)
        // hunt for low on every tick; overrun blocks receive
        asp_pkg::RX_IDLE: begin
          rx_sub_q <= 4'h1;
          rx_pbad_q <= 1'b0;
          rx_fbad_q <= 1'b0;
          rx_stop_q <= 1'b0;
          if (rx_en && !overrun_flag_q && !filt_q) rx_st_q <= asp_pkg::RX_START;
        end
        asp_pkg::RX_START: if (vote_now) begin
          rx_bit_q <= 3'h0;
          rx_st_q <= vote ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
        end
        asp_pkg::RX_DATA: if (vote_now) begin
          rx_sh_q <= {vote, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == asp_pkg::LAST_DATA)
            rx_st_q <= par_en ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
        end
        asp_pkg::RX_PAR: if (vote_now) begin
          rx_pbad_q <= vote != ((^rx_sh_q) ^ ~even);
          rx_st_q <= asp_pkg::RX_STOP;
        end
        asp_pkg::RX_STOP: if (vote_now) begin
          rx_stop_q <= 1'b1;
          if (!vote) rx_fbad_q <= 1'b1;
          if (rx_done) rx_st_q <= asp_pkg::RX_IDLE;
        end
        default: rx_st_q <= asp_pkg::RX_IDLE;
      endcase
    end
  end

  // receive buffer and flags; a set wins over a same-cycle clear
  logic rx_take, rx_frame_err_flag_now;
  assign rx_take = rx_done & ~rfull_q;
  assign rx_frame_err_flag_now = rx_fbad_q | ~vote;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_hold_q <= asp_pkg::HOLD_RST;
      rfull_q <= 1'b0;
      parity_err_flag_q <= 1'b0;
      frame_err_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
      rx_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= rx_take;
      // overrun leaves the held character alone
      if (rx_take) rx_hold_q <= rx_sh_q;
      rfull_q <= rx_take | (rfull_q & ~clr_rx);
      parity_err_flag_q <= (rx_take & rx_pbad_q) | (parity_err_flag_q & ~clr_rx);
      frame_err_flag_q <= (rx_take & rx_frame_err_flag_now) | (frame_err_flag_q & ~clr_rx);
      overrun_flag_q <= (rx_done & rfull_q) | (overrun_flag_q & ~clr_rx);
    end
  end
  assign rx_irq = rx_irq_q;

  // checks
  // tick period
  a_baud_div_13: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && baud_sel == 3'h0) ##13 (baud_sel == 3'h0) |-> tick)
    else $error("divide by 13 tick spacing wrong");
  a_tx_idle_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st_q == asp_pkg::TX_IDLE && !route_q[asp_pkg::R_TX]) |=> tx_pin_primary)
    else $error("tx pin low while idle");
  a_start_bit_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st_q == asp_pkg::TX_START && !route_q[asp_pkg::R_TX]) |=> !tx_pin_primary)
    else $error("start bit not low");
  a_tx_irq_empty: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_go |=> (tx_empty_q && tx_irq))
    else $error("tx event without empty flag");
  a_unarmed_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && wr_idx == asp_pkg::IDX_DATA && !armed_q && tx_empty_q) |=> tx_empty_q)
    else $error("unarmed write cleared empty flag");
  a_frame_runs: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st_q != asp_pkg::TX_IDLE && !tx_end) |=> (tx_st_q != asp_pkg::TX_IDLE))
    else $error("frame cut short");
  a_rx_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (clr_rx && !rx_done) |=> (!rfull_q && !parity_err_flag_q && !frame_err_flag_q && !overrun_flag_q))
    else $error("armed data read did not clear flags");
  a_overrun_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_done && rfull_q) |=> ($stable(rx_hold_q) && overrun_flag_q))
    else $error("overrun changed held data");
  a_filter_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (nf_sel == 2'h1 && $past(nf_sel) == 2'h1 && $changed(filt_q))
      |-> ($past(flt_cnt_q) == 7'h1E))
    else $error("filter passed a short pulse");
  c_tx_frame: cover property (@(posedge aclk) disable iff (!aresetn) tx_end);
  c_rx_load: cover property (@(posedge aclk) disable iff (!aresetn) rx_take);
  c_overrun: cover property (@(posedge aclk) disable iff (!aresetn) rx_done && rfull_q);
  c_timer_rx: cover property (@(posedge aclk) disable iff (!aresetn)
    rx_take && baud_sel == asp_pkg::BAUD_TIMER);
endmodule : asp_uart
`default_nettype wire
